// ==== logic/rie_top.sv ====
`timescale 1ns/10ps
module rie_top
  import rie_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic insn_valid_i,
  input wire logic [13:0] insn_i,
  input wire logic [12:0] stack_top_entry_i,
  output logic [1:0] qph_o,
  output logic busy_o,
  output logic stack_pop_o,
  output logic pc_load_o,
  output logic [12:0] program_counter_o,
  output logic w_load_o,
  output logic [7:0] w_o,
  output logic status_we_o
);
  ////////////////////////////////////////////////////////////////////
  // reset release
  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////
  // quarter phase
  logic [1:0] qph;
  logic cyc_end;

  rie_qphase u_qph (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .qph_o(qph),
    .cyc_end_o(cyc_end)
  );

  ////////////////////////////////////////////////////////////////////
  // decode
  logic is_retlit;
  logic is_ret;

  assign is_retlit = (insn_i[13:RETLIT_TOP_POS] == RETLIT_TOP)
                   && (insn_i[11:RETLIT_NIB_POS] == RETLIT_NIB);
  assign is_ret = (insn_i == RETURN_WORD);

  ////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    rie_state_t st;
    logic lit_op;
    logic [7:0] lit;
    logic [1:0] qph;
    logic busy;
    logic pop;
    logic pc_load;
    logic [12:0] pc;
    logic w_load;
    logic [7:0] w;
    logic status_we;
  } rie_regs_t;

  rie_regs_t s_r;
  rie_regs_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.qph = qph;
    s_nxt.pop = 1'b0;
    s_nxt.pc_load = 1'b0;
    s_nxt.w_load = 1'b0;
    s_nxt.status_we = 1'b0;
    case (s_r.st)
      RIE_IDLE: begin
        s_nxt.busy = 1'b0;
        if (qph == QPH_Q1 && insn_valid_i && (is_retlit || is_ret)) begin
          s_nxt.st = RIE_EXEC;
          s_nxt.lit_op = is_retlit;
          s_nxt.busy = 1'b1;
        end
      end
      RIE_EXEC: begin
        if (qph == QPH_Q2 && s_r.lit_op) begin
          s_nxt.lit = insn_i[LIT_W-1:0];
        end
        if (qph == QPH_Q4) begin
          s_nxt.pop = 1'b1;
          s_nxt.pc_load = 1'b1;
          s_nxt.pc = stack_top_entry_i;
          if (s_r.lit_op) begin
            s_nxt.w_load = 1'b1;
            s_nxt.w = s_r.lit;
          end
          s_nxt.st = RIE_WAIT;
        end
      end
      RIE_WAIT: begin
        if (cyc_end) begin
          // busy covers q4 too, idle drops it
          s_nxt.st = RIE_IDLE;
        end
      end
      default: begin
        s_nxt.st = RIE_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{st: RIE_IDLE, lit_op: 1'b0, lit: W_RST, qph: QPH_Q1, busy: 1'b0,
               pop: 1'b0, pc_load: 1'b0, pc: PC_RST, w_load: 1'b0, w: W_RST,
               status_we: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign qph_o = s_r.qph;
  assign busy_o = s_r.busy;
  assign stack_pop_o = s_r.pop;
  assign pc_load_o = s_r.pc_load;
  assign program_counter_o = s_r.pc;
  assign w_load_o = s_r.w_load;
  assign w_o = s_r.w;
  assign status_we_o = s_r.status_we;

  ////////////////////////////////////////////////////////////////////
  // checks
  a_pop_in_q4: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(s_r.pop) |-> s_r.qph == QPH_Q4 && s_r.pc_load)
    else $error("pop not in q4 with pc load");

  a_pc_from_top: assert property (@(posedge clk_i) disable iff (!rst_n)
    (s_r.st == RIE_EXEC && qph == QPH_Q4) |=> s_r.pc == $past(stack_top_entry_i))
    else $error("program counter not from stack top");

  a_lit_to_w: assert property (@(posedge clk_i) disable iff (!rst_n)
    (s_r.st == RIE_EXEC && qph == QPH_Q2 && s_r.lit_op)
    |-> ##3 w_load_o && w_o == $past(insn_i[LIT_W-1:0], 3))
    else $error("literal not written to accumulator");

  a_ret_no_w: assert property (@(posedge clk_i) disable iff (!rst_n)
    (pc_load_o && !s_r.lit_op) |-> !w_load_o)
    else $error("plain return touched accumulator");

  a_two_cycles: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(busy_o) |-> busy_o [*8] ##1 (!busy_o || s_r.st == RIE_EXEC))
    else $error("return not two cycles");

  a_idle_second: assert property (@(posedge clk_i) disable iff (!rst_n)
    (s_r.st == RIE_WAIT) |=> !stack_pop_o && !pc_load_o && !w_load_o && !status_we_o
    && $stable(w_o) && $stable(program_counter_o))
    else $error("activity in second cycle");

  a_lit_decode: assert property (@(posedge clk_i) disable iff (!rst_n)
    (s_r.st == RIE_IDLE && qph == QPH_Q1 && insn_valid_i && insn_i[13:10] == 4'hd)
    |=> s_r.st == RIE_EXEC && s_r.lit_op)
    else $error("literal return not decoded");

  a_ret_decode: assert property (@(posedge clk_i) disable iff (!rst_n)
    (s_r.st == RIE_IDLE && qph == QPH_Q1 && insn_valid_i && insn_i == 14'h0008)
    |=> s_r.st == RIE_EXEC && !s_r.lit_op)
    else $error("plain return not decoded");

  a_pop_one_pulse: assert property (@(posedge clk_i) disable iff (!rst_n)
    stack_pop_o |=> !stack_pop_o)
    else $error("pop longer than one phase");

  a_pop_with_pc: assert property (@(posedge clk_i) disable iff (!rst_n)
    pc_load_o |-> stack_pop_o)
    else $error("program counter load without pop");

  a_pop_after_take: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(busy_o) |-> !stack_pop_o [*3] ##1 stack_pop_o)
    else $error("pop not at q4 of first cycle");

  a_w_load_pulse: assert property (@(posedge clk_i) disable iff (!rst_n)
    w_load_o |=> !w_load_o)
    else $error("accumulator load longer than one phase");

  a_w_only_lit: assert property (@(posedge clk_i) disable iff (!rst_n)
    w_load_o |-> pc_load_o && s_r.lit_op)
    else $error("accumulator load outside literal return");

  a_w_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
    !w_load_o |-> $stable(w_o))
    else $error("accumulator changed without load");

  a_pc_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
    !pc_load_o |-> $stable(program_counter_o))
    else $error("program counter changed without load");

  a_status_quiet: assert property (@(posedge clk_i) disable iff (!rst_n)
    !status_we_o)
    else $error("status write during return");

  a_phase_wrap: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_r.qph == QPH_Q4 |=> s_r.qph == QPH_Q1)
    else $error("quarter phase did not wrap");

  a_exec_len: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(busy_o) |-> (s_r.st == RIE_EXEC) [*3] ##1 (s_r.st == RIE_WAIT) [*4])
    else $error("cycle split of return wrong");
endmodule

// ==== logic/rie_pkg.sv ====
package rie_pkg;
  // instruction word layout
  localparam int INSN_W = 14;
  localparam int LIT_W = 8;
  localparam int PC_W = 13;
  localparam logic [1:0] RETLIT_TOP = 2'h3;
  localparam logic [1:0] RETLIT_NIB = 2'h1;
  localparam int RETLIT_TOP_POS = 12;
  localparam int RETLIT_NIB_POS = 10;
  localparam logic [13:0] RETURN_WORD = 14'h0008;
  // quarter phases per instruction cycle
  localparam int QPH_W = 2;
  localparam logic [1:0] QPH_Q1 = 2'h0;
  localparam logic [1:0] QPH_Q2 = 2'h1;
  localparam logic [1:0] QPH_Q4 = 2'h3;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;

  typedef enum logic [2:0] {
    RIE_IDLE = 3'h1,
    RIE_EXEC = 3'h2,
    RIE_WAIT = 3'h4
  } rie_state_t;
endpackage

// ==== logic/rie_qphase.sv ====
`timescale 1ns/10ps
// quarter phase counter: q1..q4 then wraps
module rie_qphase
  import rie_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic [1:0] qph_o,
  output logic cyc_end_o
);
  typedef struct packed {
    logic [1:0] qph;
  } rie_qph_regs_t;

  rie_qph_regs_t s_r;
  rie_qph_regs_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.qph = s_r.qph + 2'h1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{qph: QPH_Q1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign qph_o = s_r.qph;
  assign cyc_end_o = (s_r.qph == QPH_Q4);
endmodule

// ==== bench/tb_return_instruction_exec.sv ====
`timescale 1ns/10ps
module tb_return_instruction_exec;
  import rie_pkg::*;
  typedef struct packed {
    logic [13:0] insn;
    logic [12:0] top;
    logic ld;
    logic wl;
    logic [7:0] w;
  } rie_row_t;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic insn_valid_i = 1'b0;
  logic [13:0] insn_i = 14'h0000;
  logic [12:0] stack_top_entry_i = 13'h0000;
  logic [1:0] qph_o;
  logic busy_o, stack_pop_o, pc_load_o, w_load_o, status_we_o;
  logic [12:0] program_counter_o;
  logic [7:0] w_o;
  int error_cnt = 0;
  int n_checks = 0;
  rie_row_t rows [8] = '{'{14'h3400, 13'h1abc, 1'b1, 1'b1, 8'h00},
    '{14'h37ff, 13'h0fff, 1'b1, 1'b1, 8'hff}, '{14'h0008, 13'h1555, 1'b1, 1'b0, 8'hff},
    '{14'h35a5, 13'h0aaa, 1'b1, 1'b1, 8'ha5}, '{14'h0009, 13'h0001, 1'b0, 1'b0, 8'ha5},
    '{14'h0000, 13'h0002, 1'b0, 1'b0, 8'ha5}, '{14'h3800, 13'h0003, 1'b0, 1'b0, 8'ha5},
    '{14'h0008, 13'h0000, 1'b1, 1'b0, 8'ha5}};

  rie_top i_rie_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .insn_valid_i(insn_valid_i),
    .insn_i(insn_i), .stack_top_entry_i(stack_top_entry_i), .qph_o(qph_o), .busy_o(busy_o),
    .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o), .program_counter_o(program_counter_o),
    .w_load_o(w_load_o), .w_o(w_o), .status_we_o(status_we_o));

  initial begin
    forever #20 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic run(input rie_row_t r);
    int busy_n;
    logic seen;
    logic wl;
    busy_n = 0;
    seen = 1'b0;
    wl = 1'b0;
    @(posedge clk_i);
    insn_valid_i <= 1'b1;
    insn_i <= r.insn;
    stack_top_entry_i <= r.top;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (busy_n > 0) begin
        insn_valid_i <= 1'b0;
        insn_i <= ~r.insn;
      end
      #1;
      if (busy_o === 1'b1) busy_n++;
      chk("status_we", status_we_o, 0);
      if (stack_pop_o === 1'b1) begin
        seen = 1'b1;
        wl = w_load_o;
        chk("pc_load", pc_load_o, 1);
        chk("pc", program_counter_o, r.top);
        chk("qph", qph_o, QPH_Q4);
      end
      if (seen && busy_o !== 1'b1) break;
    end
    if (r.ld && busy_o !== 1'b0) begin
      error_cnt++;
      report_and_stop();
    end
    @(posedge clk_i);
    insn_valid_i <= 1'b0;
    chk("pop", seen, r.ld);
    chk("busy_len", busy_n, r.ld ? 8 : 0);
    chk("w_load", wl, r.wl);
    chk("w", w_o, r.w);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'b1;
    chk("w_rst", w_o, W_RST);
    chk("pc_rst", program_counter_o, PC_RST);
    repeat (3) @(posedge clk_i);
    foreach (rows[i]) run(rows[i]);
    // reset in mid-instruction
    @(posedge clk_i);
    insn_valid_i <= 1'b1;
    insn_i <= 14'h3477;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b0;
    insn_valid_i <= 1'b0;
    #1;
    chk("busy_arst", busy_o, 0);
    chk("w_arst", w_o, W_RST);
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    run('{14'h3633, 13'h0042, 1'b1, 1'b1, 8'h33});
    report_and_stop();
  end
endmodule
